// file: design/sms_ctrl.sv
// Serial peripheral controller: registers, master and slave engines
// Contract
// [RULE1] Master data write starts transfer immediately
// [RULE2] Transfer end sets done flag, interrupt
// [RULE3] Frame size code selects 1 to 8 bits
// [RULE4] Receive shifts in while transmitting
// [RULE5] Most significant bit goes first
// [RULE6] Write while busy dropped, collision flagged
// [RULE7] Full receive buffer drops word, overrun
// [RULE8] Slave done when select returns high
// [RULE9] External master selects low, clocks data
// [RULE10] Slave word written before next transfer
// [RULE11] Unselected slave releases its output
// [RULE12] Select low as master: fault, go offline
// [RULE13] Selected status mirrors select pin low
// [RULE14] Software checks select before becoming master
// [RULE15] Phase picks first or second sample edge
// [RULE16] Polarity sets clock idle level
// [RULE17] Both ends share phase and polarity
// [RULE18] Rate register used only as master
// [RULE19] Clock is half sysclk over rate+1
// [RULE20] Bit count shows latest bit moved
// [RULE21] Busy flag follows master transfer
// [RULE22] Event flags cleared only by software
// [RULE23] Enable and master bits select role
`timescale 1ns/1ps
module sms_ctrl
   import sms_pkg::*;
(
   input  wire logic        ref_clk,       // 25 MHz system clock
   input  wire logic        rst_b,         // async reset, active low
   input  wire logic [7:0]  reg_addr,      // register address
   input  wire logic [7:0]  reg_wdata,     // write data
   input  wire logic        reg_we,        // write strobe
   input  wire logic        reg_re,        // read strobe
   output logic      [7:0]  reg_rdata,     // read data, one cycle later
   output logic             irq_req,       // any event flag set
   input  wire logic        slave_select_n,// select pin, active low
   input  wire logic        sck_in,        // clock pin level
   output logic             sck_out,       // clock pin drive
   output logic             sck_oe,        // clock pin enable
   input  wire logic        mosi_in,       // master-out pin level
   output logic             mosi_out,      // master-out drive
   output logic             mosi_oe,       // master-out enable
   input  wire logic        miso_in,       // master-in pin level
   output logic             miso_out,      // master-in drive
   output logic             miso_oe        // master-in enable
);
   import sms_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   sms_pins_t  pins_raw, pins;
   sms_state_t state, next_state;
   sms_flags_t flags, next_flags;
   logic       block_enable, next_block_enable;
   logic       master_enable, next_master_enable;
   logic       clock_phase, next_clock_phase;
   logic       clock_polarity, next_clock_polarity;
   logic [2:0] frame_size, next_frame_size;
   logic [7:0] clock_rate, next_clock_rate;
   logic [2:0] bit_count, next_bit_count;
   logic [7:0] shreg, next_shreg;
   logic [7:0] div_cnt, next_div_cnt;
   logic [3:0] edge_cnt, next_edge_cnt;
   logic [2:0] samp_cnt, next_samp_cnt;
   logic       sck_q, next_sck_q;
   logic       mosi_q, next_mosi_q;
   logic       miso_q, next_miso_q;
   logic       sck_prev, ssn_prev;
   logic [7:0] rdata_q, next_rdata_q;
   logic       wr_data, wr_ctrl, wr_cfg, wr_ckr, rd_data;
   logic       busy, tick, last_edge, sample_edge;
   logic       s_edge, s_lead, s_sample, s_shift;
   logic       mode_fault_flag_cond, rx_push, fifo_ready, fifo_valid;
   logic [7:0] rx_word, fifo_head;

   // ************************************************************
   // Pin synchroniser and receive buffer
   // ************************************************************
   assign pins_raw = '{ssn: slave_select_n, sck: sck_in, mosi: mosi_in, miso: miso_in};

   sms_sync #(.W(PIN_W), .INIT(PINS_IDLE)) u_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .async_in (pins_raw),
      .filt_out (pins)
   );

   // Reading the data register pops the oldest received word
   sms_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (rx_push),
      .in_ready  (fifo_ready),
      .in_data   (rx_word),
      .out_valid (fifo_valid),
      .out_ready (rd_data),
      .out_data  (fifo_head)
   );

   // ************************************************************
   // Decode and combinational helpers
   // ************************************************************
   assign wr_data     = reg_we && (reg_addr == ADDR_DATA);
   assign wr_ctrl     = reg_we && (reg_addr == ADDR_CTRL);
   assign wr_cfg      = reg_we && (reg_addr == ADDR_CFG);
   assign wr_ckr      = reg_we && (reg_addr == ADDR_CKR);
   assign rd_data     = reg_re && (reg_addr == ADDR_DATA);
   assign busy        = (state != ST_IDLE);
   assign tick        = (state == ST_MSHIFT) && (div_cnt == clock_rate); // [RULE19] [RULE18]
   assign last_edge   = (edge_cnt == {frame_size, 1'b1}); // [RULE3]
   assign sample_edge = (edge_cnt[0] == clock_phase); // [RULE15]
   assign mode_fault_flag_cond   = block_enable && master_enable && !pins.ssn; // [RULE12]
   // Slave edges seen on the filtered clock, never on a raw stage
   assign s_edge      = (pins.sck != sck_prev);
   assign s_lead      = s_edge && (pins.sck != clock_polarity);
   assign s_sample    = clock_phase ? (s_edge && !s_lead) : s_lead; // [RULE15]
   assign s_shift     = clock_phase ? s_lead : (s_edge && !s_lead);

   // ************************************************************
   // Transfer engine
   // ************************************************************
   always_comb begin
      next_state     = state;
      next_shreg     = shreg;
      next_div_cnt   = div_cnt;
      next_edge_cnt  = edge_cnt;
      next_samp_cnt  = samp_cnt;
      next_bit_count = bit_count;
      next_sck_q     = sck_q;
      next_mosi_q    = mosi_q;
      next_miso_q    = miso_q;
      rx_push        = 1'b0;
      rx_word        = shreg;
      unique case (state)
         ST_IDLE: begin
            next_sck_q = clock_polarity; // [RULE16]
            if (wr_data) begin
               next_shreg = reg_wdata; // [RULE10]
            end
            if (wr_data && block_enable && master_enable && !mode_fault_flag_cond) begin
               next_state    = ST_MSHIFT; // [RULE1]
               next_mosi_q   = reg_wdata[WORD_W-1]; // [RULE5]
               next_div_cnt  = 8'h00;
               next_edge_cnt = 4'h0;
               next_samp_cnt = 3'h0;
            end else if (block_enable && !master_enable && !pins.ssn && ssn_prev) begin
               // Word in the shift register now is what the master gets
               next_state    = ST_SLAVE; // [RULE10]
               next_samp_cnt = 3'h0;
               next_miso_q   = shreg[WORD_W-1]; // [RULE5]
            end
         end
         ST_MSHIFT: begin
            next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
            if (!block_enable || !master_enable) begin
               next_state = ST_IDLE;
            end else if (tick) begin
               next_sck_q    = !sck_q;
               next_edge_cnt = edge_cnt + 4'h1;
               if (sample_edge) begin
                  next_shreg     = {shreg[WORD_W-2:0], pins.miso}; // [RULE4] [RULE5]
                  next_bit_count = samp_cnt; // [RULE20]
                  next_samp_cnt  = samp_cnt + 3'h1;
               end else begin
                  next_mosi_q = shreg[WORD_W-1]; // [RULE5]
               end
               if (last_edge) begin
                  next_state = ST_IDLE; // [RULE21]
                  rx_push    = 1'b1; // [RULE4]
                  // Second-edge sampling takes its last bit on this very edge
                  rx_word    = next_shreg & (WORD_MASK >> (3'd7 - frame_size)); // [RULE3]
               end
            end
         end
         ST_SLAVE: begin
            if (!block_enable || master_enable) begin
               next_state = ST_IDLE;
            end else if (pins.ssn) begin
               next_state = ST_IDLE; // [RULE8]
               rx_push    = 1'b1;
            end else if (s_sample) begin
               next_shreg     = {shreg[WORD_W-2:0], pins.mosi}; // [RULE5]
               next_bit_count = samp_cnt; // [RULE20]
               next_samp_cnt  = samp_cnt + 3'h1;
            end else if (s_shift) begin
               next_miso_q = shreg[WORD_W-1];
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state     <= ST_IDLE;
         shreg     <= DATA_RESET;
         div_cnt   <= 8'h00;
         edge_cnt  <= 4'h0;
         samp_cnt  <= 3'h0;
         bit_count <= CFG_RESET[CFG_BC_LSB+:3];
         sck_q     <= CFG_RESET[CFG_POL];
         mosi_q    <= 1'b0;
         miso_q    <= 1'b0;
         sck_prev  <= PINS_IDLE.sck;
         ssn_prev  <= PINS_IDLE.ssn;
      end else begin
         state     <= next_state;
         shreg     <= next_shreg;
         div_cnt   <= next_div_cnt;
         edge_cnt  <= next_edge_cnt;
         samp_cnt  <= next_samp_cnt;
         bit_count <= next_bit_count;
         sck_q     <= next_sck_q;
         mosi_q    <= next_mosi_q;
         miso_q    <= next_miso_q;
         sck_prev  <= pins.sck;
         ssn_prev  <= pins.ssn;
      end
   end

   // ************************************************************
   // Registers and flags
   // ************************************************************
   // Hardware sets win over a software clear in the same cycle
   always_comb begin
      next_flags          = flags;
      next_block_enable   = block_enable;
      next_master_enable  = master_enable;
      next_clock_phase    = clock_phase;
      next_clock_polarity = clock_polarity;
      next_frame_size     = frame_size;
      next_clock_rate     = clock_rate;
      next_rdata_q        = 8'h00;
      if (wr_ctrl) begin
         next_flags         = '{done: reg_wdata[CTL_DONE], write_collision_flag: reg_wdata[CTL_WRITE_COLLISION_FLAG],
                                mode_fault_flag: reg_wdata[CTL_MODE_FAULT_FLAG], ovrn: reg_wdata[CTL_OVRN]}; // [RULE22]
         next_block_enable  = reg_wdata[CTL_EN]; // [RULE23]
         next_master_enable = reg_wdata[CTL_MST]; // [RULE23]
      end
      if (wr_cfg) begin
         // Changing phase or polarity mid-transfer corrupts the word
         next_clock_phase    = reg_wdata[CFG_PHASE]; // [RULE17]
         next_clock_polarity = reg_wdata[CFG_POL];
         next_frame_size     = reg_wdata[CFG_FS_LSB+:3];
      end
      if (wr_ckr) begin
         next_clock_rate = reg_wdata;
      end
      if (rx_push) begin
         next_flags.done = 1'b1; // [RULE2] [RULE8]
      end
      if (wr_data && busy) begin
         next_flags.write_collision_flag = 1'b1; // [RULE6]
      end
      if (rx_push && !fifo_ready) begin
         next_flags.ovrn = 1'b1; // [RULE7]
      end
      if (mode_fault_flag_cond) begin
         next_flags.mode_fault_flag    = 1'b1; // [RULE12]
         next_block_enable  = 1'b0;
         next_master_enable = 1'b0;
      end
      if (reg_re) begin
         unique case (reg_addr)
            ADDR_CTRL: next_rdata_q = {flags.done, flags.write_collision_flag, flags.mode_fault_flag, flags.ovrn,
                                       (state == ST_MSHIFT), !pins.ssn,
                                       master_enable, block_enable}; // [RULE13] [RULE21] [RULE14]
            ADDR_CFG:  next_rdata_q = {clock_phase, clock_polarity, bit_count, frame_size};
            ADDR_CKR:  next_rdata_q = clock_rate;
            ADDR_DATA: next_rdata_q = fifo_valid ? fifo_head : 8'h00;
            default:   next_rdata_q = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags          <= '{done: CTRL_RESET[CTL_DONE], write_collision_flag: CTRL_RESET[CTL_WRITE_COLLISION_FLAG],
                             mode_fault_flag: CTRL_RESET[CTL_MODE_FAULT_FLAG], ovrn: CTRL_RESET[CTL_OVRN]};
         block_enable   <= CTRL_RESET[CTL_EN];
         master_enable  <= CTRL_RESET[CTL_MST];
         clock_phase    <= CFG_RESET[CFG_PHASE];
         clock_polarity <= CFG_RESET[CFG_POL];
         frame_size     <= CFG_RESET[CFG_FS_LSB+:3];
         clock_rate     <= CKR_RESET;
         rdata_q        <= 8'h00;
      end else begin
         flags          <= next_flags;
         block_enable   <= next_block_enable;
         master_enable  <= next_master_enable;
         clock_phase    <= next_clock_phase;
         clock_polarity <= next_clock_polarity;
         frame_size     <= next_frame_size;
         clock_rate     <= next_clock_rate;
         rdata_q        <= next_rdata_q;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign reg_rdata = rdata_q;
   assign irq_req   = flags.done | flags.write_collision_flag | flags.mode_fault_flag | flags.ovrn; // [RULE2]
   assign sck_out   = sck_q;
   assign mosi_out  = mosi_q;
   assign miso_out  = miso_q;
   assign sck_oe    = block_enable && master_enable; // [RULE23]
   assign mosi_oe   = block_enable && master_enable;
   assign miso_oe   = (state == ST_SLAVE) && !pins.ssn; // [RULE11]

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence master_start_s;
      wr_data && !busy && block_enable && master_enable && !mode_fault_flag_cond;
   endsequence
   sequence busy_next_s;
      ##1 (state == ST_MSHIFT);
   endsequence

   master_start_a: assert property (master_start_s |-> busy_next_s) // [RULE1]
      else $error("master transfer did not start on data write");
   done_flag_a: assert property ($fell(state == ST_MSHIFT) && $past(rx_push) |-> flags.done && irq_req) // [RULE2]
      else $error("done flag missing after master transfer");
   write_coll_a: assert property (wr_data && busy |=> flags.write_collision_flag && ($stable(shreg) || $past(s_sample) || $past(tick))) // [RULE6]
      else $error("collision write not flagged");
   overrun_drop_a: assert property (rx_push && !fifo_ready |=> flags.ovrn) // [RULE7]
      else $error("overrun not flagged on full buffer");
   mode_fault_a: assert property (mode_fault_flag_cond |=> flags.mode_fault_flag && !block_enable && !master_enable) // [RULE12]
      else $error("mode fault did not take block offline");
   sel_status_a: assert property (reg_re && reg_addr == ADDR_CTRL |=> reg_rdata[CTL_SEL] == !$past(pins.ssn)) // [RULE13]
      else $error("selected status wrong");
   idle_level_a: assert property (state == ST_IDLE && $past(state) == ST_IDLE |-> sck_out == $past(clock_polarity)) // [RULE16]
      else $error("clock idle level wrong");
   half_period_a: assert property (state == ST_MSHIFT && $changed(sck_out) |-> $past(div_cnt) == $past(clock_rate)) // [RULE19]
      else $error("clock half period wrong");
   miso_release_a: assert property (pins.ssn |-> !miso_oe) // [RULE11]
      else $error("unselected slave drives its output");
   busy_bits_a: assert property (master_start_s ##1 (state == ST_MSHIFT) |-> (state == ST_MSHIFT) [*2]) // [RULE21]
      else $error("busy dropped too early");
endmodule // sms_ctrl

// file: shared/sms_pkg.sv
// Package: shared constants and types of the serial peripheral controller
package sms_pkg;
   // ************************************************************
   // Register addresses and reset values
   // ************************************************************
   localparam logic [7:0] ADDR_CFG   = 8'h9a;
   localparam logic [7:0] ADDR_DATA  = 8'h9b;
   localparam logic [7:0] ADDR_CKR   = 8'h9d;
   localparam logic [7:0] ADDR_CTRL  = 8'hf8;
   localparam logic [7:0] CFG_RESET  = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CKR_RESET  = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CFG_PHASE  = 7;
   localparam int CFG_POL    = 6;
   localparam int CFG_BC_LSB = 3;
   localparam int CFG_FS_LSB = 0;
   localparam int CTL_DONE   = 7;
   localparam int CTL_WRITE_COLLISION_FLAG   = 6;
   localparam int CTL_MODE_FAULT_FLAG   = 5;
   localparam int CTL_OVRN   = 4;
   localparam int CTL_BUSY   = 3;
   localparam int CTL_SEL    = 2;
   localparam int CTL_MST    = 1;
   localparam int CTL_EN     = 0;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int WORD_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int PIN_W      = 4;
   localparam logic [7:0] WORD_MASK = 8'hff;

   // Pin inputs, sampled together through one synchroniser
   typedef struct packed {
      logic ssn;
      logic sck;
      logic mosi;
      logic miso;
   } sms_pins_t;
   localparam sms_pins_t PINS_IDLE = '{ssn: 1'b1, sck: 1'b0, mosi: 1'b0, miso: 1'b0};

   // Sticky event flags
   typedef struct packed {
      logic done;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic ovrn;
   } sms_flags_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_MSHIFT = 2'b01,
      ST_SLAVE  = 2'b10
   } sms_state_t;
endpackage

// file: design/sms_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sms_sync #(
   parameter int             W    = 4,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         ref_clk,  // system clock
   input  wire logic         rst_b,    // async reset, active low
   input  wire logic [W-1:0] async_in, // raw pin levels
   output logic      [W-1:0] filt_out  // filtered levels
);
   // ************************************************************
   // One chain per bit
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1, s2, s3, q;
         logic next_q;
         // A change counts only once stages two and three agree
         always_comb begin
            next_q = (s2 == s3) ? s3 : q;
         end
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               s1 <= INIT[g];
               s2 <= INIT[g];
               s3 <= INIT[g];
               q  <= INIT[g];
            end else begin
               s1 <= async_in[g];
               s2 <= s1;
               s3 <= s2;
               q  <= next_q;
            end
         end
         assign filt_out[g] = q;
      end
   endgenerate
endmodule // sms_sync

// file: design/sms_fifo.sv
// Receive word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk,   // system clock
   input  wire logic             rst_b,     // async reset, active low
   input  wire logic             in_valid,  // word offered
   output logic                  in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] in_data,   // word in
   output logic                  out_valid, // word waiting
   input  wire logic             out_ready, // reader takes word
   output logic      [WIDTH-1:0] out_data   // oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   // ************************************************************
   // Pointers and fill level
   // ************************************************************
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // sms_fifo

// file: verification/sms_peer.sv
// Behavioural serial slave standing on the far side of the bus
`timescale 1ns/1ps
module sms_peer (
   input  wire logic       sel_n, // select, active low
   input  wire logic       cpol,  // clock idle level
   input  wire logic       cpha,  // sample on second edge
   input  wire logic       sck,   // serial clock
   input  wire logic       mosi,  // data from master
   input  wire logic [7:0] tx,    // word to send
   output logic            miso,  // data to master
   output logic      [7:0] rx     // bits taken in
);
   int   idx  = 0;
   logic held = 1'b0;
   // Sample on the chosen edge, step to the next bit on the trailing one
   always @(sck) begin
      if (!sel_n && ((sck != cpol) != cpha)) rx <= {rx[6:0], mosi};
      if (!sel_n && sck == cpol) idx <= idx + 1;
   end
   // Fresh word on every select
   always @(negedge sel_n) begin
      idx <= 0;
      rx <= 8'h00;
   end
   // Released line shows the inverse of its last bit, so no stale level passes
   always @(posedge sel_n) held <= tx[3'(7 - idx)];
   assign #1 miso = sel_n ? ~held : tx[3'(7 - idx)];
endmodule // sms_peer

// file: verification/testbench.sv
// Self-checking bench for the serial peripheral controller
`timescale 1ns/1ps
module testbench;
   import sms_pkg::*;
   logic       ref_clk, rst_b, reg_we, reg_re, irq_req, slave_select_n, sck_d, mosi_d;
   logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
   logic       peer_sel_n, cpol, cpha;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, peer_tx, peer_rx, r, d, got;
   logic [2:0] fs;
   wire        sck_in  = sck_oe ? sck_out : sck_d;
   wire        mosi_in = mosi_oe ? mosi_out : mosi_d;
   wire        miso_in = miso_oe ? miso_out : peer_miso;
   int         errors, cmp_count, i, seed = 34196;

   sms_ctrl dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
      .irq_req, .slave_select_n, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out,
      .mosi_oe, .miso_in, .miso_out, .miso_oe);
   sms_peer peer (.sel_n(peer_sel_n), .cpol, .cpha, .sck(sck_in), .mosi(mosi_in),
      .tx(peer_tx), .miso(peer_miso), .rx(peer_rx));

   // 25 MHz system clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Bus tasks and expectations
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic results;
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One register cycle; strobes drop a cycle later so back-to-back calls never clash
   task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      #1 {reg_we, reg_re, reg_addr, reg_wdata} = {we, ~we, a, v};
      @(posedge ref_clk);
      #1 {reg_we, reg_re} = 2'b00;
      r = reg_rdata;
   endtask
   task automatic h8;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
   // Top f+1 bits of a word, right-aligned, as received when shifted most significant first
   function automatic logic [7:0] top_bits(input logic [7:0] w, input logic [2:0] f);
      return w >> (3'd7 - f);
   endfunction
   // One master word, optionally with a refused second write
   task automatic xfer(input logic [7:0] v, input logic col);
      peer_tx = 8'($random(seed));
      peer_sel_n = 1'b0;
      acc(1'b1, ADDR_DATA, v);
      if (col) acc(1'b1, ADDR_DATA, ~v);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(r & 8'h08, 8'h08);
      for (int n = 0; n < 600 && r[CTL_DONE] !== 1'b1; n++) acc(1'b0, ADDR_CTRL, 8'h00);
      if (r[CTL_DONE] !== 1'b1) begin
         errors++;
         results;
      end
      chk(r & 8'hc8 | {7'h00, irq_req}, {1'b1, col, 6'h01});
      peer_sel_n = 1'b1;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {reg_we, reg_re, sck_d, mosi_d, cpol, cpha, reg_addr, reg_wdata, peer_tx} = '0;
      {rst_b, slave_select_n, peer_sel_n} = 3'b011;
      repeat (2) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      acc(1'b0, ADDR_CFG, 8'h00);
      chk(r, CFG_RESET);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(r, CTRL_RESET);
      acc(1'b0, 8'h9c, 8'h00);
      chk(r, 8'h00);
      // Random sizes, modes and rates; first words are 1 and 8 bits
      for (i = 0; i < 12; i++) begin
         fs = (i < 2) ? 3'(i * 7) : 3'($random(seed));
         {cpha, cpol} = 2'($random(seed));
         acc(1'b1, ADDR_CTRL, 8'h00);
         acc(1'b1, ADDR_CFG, {cpha, cpol, 3'b000, fs});
         // Pin synchroniser lag needs five cycles per half period to receive
         acc(1'b1, ADDR_CKR, 8'h04 + (8'($random(seed)) & 8'h03));
         acc(1'b1, ADDR_CTRL, 8'h03);
         d = 8'($random(seed));
         xfer(d, i == 1);
         chk(peer_rx, top_bits(d, fs));
         acc(1'b0, ADDR_DATA, 8'h00);
         chk(r, top_bits(peer_tx, fs));
         chk({6'h00, sck_oe, sck_out}, {6'h00, 1'b1, cpol});
         acc(1'b0, ADDR_CFG, 8'h00);
         chk(r, {cpha, cpol, fs, fs});
      end
      // Thirty-three unread words overflow the receive queue
      acc(1'b1, ADDR_CTRL, 8'h00);
      {cpha, cpol} = 2'b00;
      acc(1'b1, ADDR_CFG, 8'h00);
      for (i = 0; i < 33; i++) begin
         acc(1'b1, ADDR_CTRL, 8'h03);
         xfer(8'(i), 1'b0);
      end
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(r & 8'h10, 8'h10);
      repeat (33) acc(1'b0, ADDR_DATA, 8'h00);
      chk(r, 8'h00);
      // Select pulled low while master: fault and off-line
      acc(1'b1, ADDR_CTRL, 8'h03);
      slave_select_n = 1'b0;
      h8;
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(r, 8'h24);
      chk({6'h00, sck_oe, irq_req}, 8'h01);
      slave_select_n = 1'b1;
      h8;
      // Bench as outside master, mode zero, word loaded before select
      acc(1'b1, ADDR_CTRL, 8'h00);
      acc(1'b1, ADDR_CFG, 8'h07);
      acc(1'b1, ADDR_CTRL, 8'h01);
      acc(1'b1, ADDR_DATA, 8'h3c);
      d = 8'($random(seed));
      slave_select_n = 1'b0;
      h8;
      for (i = 7; i >= 0; i--) begin
         mosi_d = d[i];
         h8;
         got[i] = miso_in;
         sck_d = 1'b1;
         h8;
         sck_d = 1'b0;
      end
      h8;
      chk({7'h00, miso_oe}, 8'h01);
      slave_select_n = 1'b1;
      h8;
      chk(got, 8'h3c);
      chk({7'h00, miso_oe}, 8'h00);
      acc(1'b0, ADDR_CTRL, 8'h00);
      chk(r, 8'h81);
      acc(1'b0, ADDR_DATA, 8'h00);
      chk(r, d);
      results;
   end
endmodule // testbench
